// ===== fan_ui_pkg.sv
// Package for the thermostat fan speed controller with its button and display interface.
// Assumes one 10 MHz system clock; temperatures are signed whole degrees Celsius.
package fan_ui_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ          = 10000000;
  localparam int unsigned CLK_NS          = 1000000000 / CLK_HZ;
  localparam int unsigned SET_TIMEOUT_S   = 5;
  localparam int unsigned SET_TIMEOUT_CYC = SET_TIMEOUT_S * CLK_HZ;
  localparam int unsigned DEBOUNCE_MS     = 20;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_MS        = 250;
  localparam int unsigned BLINK_CYC       = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned DIGIT_US        = 2000;
  localparam int unsigned DIGIT_CYC       = DIGIT_US * (CLK_HZ / 1000000);

  // ==========================================================
  // Control curve thresholds in degrees
  localparam int FULL_SPEED_DIFF = 5;
  localparam int START_DIFF      = 1;
  localparam int STOP_DIFF       = 0;

  // ==========================================================
  // Default target and limits
  localparam logic signed [7:0] TARGET_RESET = 8'sh14;
  localparam logic signed [7:0] TARGET_MIN   = 8'sh05;
  localparam logic signed [7:0] TARGET_MAX   = 8'sh23;

  // ==========================================================
  // Display segment lines and digit selects
  localparam int SEG_W   = 7;
  localparam int DIGIT_N = 2;

  // Segment pattern for one digit, bits g..a
  typedef struct packed {
    logic [SEG_W-1:0]   seg;
    logic [DIGIT_N-1:0] digit_sel;
  } led_drive_t;

  typedef struct packed {
    logic up;
    logic down;
  } buttons_t;

endpackage

// ===== button_debounce.sv
// Debounces one push button and emits one pulse per settled press.
// Assumes the raw level is synchronous to sys_clk and active high.
`timescale 1ns/100ps
module button_debounce #(
  parameter int unsigned STABLE_CYC = fan_ui_pkg::DEBOUNCE_CYC
)(
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic raw,
  output logic      press
);

  logic        state_reg;
  logic [31:0] cnt_reg;

  // ==========================================================
  // Settle counter: level taken only after it holds steady
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_reg <= 1'b0;
      cnt_reg   <= 32'h0;
      press     <= 1'b0;
    end
    else if (ce)
    begin
      press <= 1'b0;
      if (raw == state_reg)
        cnt_reg <= 32'h0;
      else if (cnt_reg >= STABLE_CYC - 1)
      begin
        state_reg <= raw;
        cnt_reg   <= 32'h0;
        press     <= raw;                 // One pulse per rising edge
      end
      else
        cnt_reg <= cnt_reg + 32'h1;
    end
  end

endmodule

// ===== fan_ui_ctrl.sv
// Fan speed controller: temperature curve, two-button target set, two-digit display.
// Assumes synchronous inputs on sys_clk and a signed whole-degree sensor reading.
//
// Behaviour
// - More than 5 below target: full speed
// - Within 5: speed linear in difference
// - Start only above 1 below, at the curve speed for that difference
// - Running: stay on until difference reaches zero
// - Show Celsius values across two digits
// - Multiplex digits, one lit at a time
// - Seven shared segments plus two selects
// - Any press enters blinking target set mode
// - Up raises, down lowers target one step
// - Five idle seconds return to measured display
// - Debounce both buttons before acting
`timescale 1ns/100ps
module fan_ui_ctrl #(
  parameter int unsigned     FREQ_W      = 8,
  parameter logic [7:0]      FREQ_MIN    = 8'h14,
  parameter logic [7:0]      FREQ_MAX    = 8'h3c,
  parameter logic signed [7:0] TGT_MIN   = fan_ui_pkg::TARGET_MIN,
  parameter logic signed [7:0] TGT_MAX   = fan_ui_pkg::TARGET_MAX,
  parameter int unsigned     TIMEOUT_CYC = fan_ui_pkg::SET_TIMEOUT_CYC,
  parameter int unsigned     DEB_CYC     = fan_ui_pkg::DEBOUNCE_CYC,
  parameter int unsigned     BLINK_CYC   = fan_ui_pkg::BLINK_CYC,
  parameter int unsigned     DIGIT_CYC   = fan_ui_pkg::DIGIT_CYC
)(
  input  wire logic                   sys_clk,
  input  wire logic                   srst,
  input  wire logic                   ce,
  input  wire logic signed [7:0]      temp_meas,
  input  wire fan_ui_pkg::buttons_t   buttons,
  output logic [FREQ_W-1:0]           motor_freq,
  output logic                        motor_run,
  output fan_ui_pkg::led_drive_t      led,
  output logic signed [7:0]           target,
  output logic                        set_mode
);

  typedef enum logic [0:0] {ST_STOP, ST_RUN} run_state_t;

  run_state_t        run_reg;
  logic              up_press;
  logic              dn_press;
  logic [31:0]       idle_reg;
  logic [31:0]       blink_cnt_reg;
  logic              blink_on_reg;
  logic [31:0]       mux_cnt_reg;
  logic              digit_reg;
  logic signed [8:0] diff;
  logic [FREQ_W-1:0] freq_next;
  logic signed [7:0] shown;
  logic [7:0]        mag;
  logic [3:0]        tens;
  logic [3:0]        ones;
  logic [3:0]        nib;
  logic [6:0]        seg_pat;

  // ==========================================================
  // Button debouncers
  button_debounce #(.STABLE_CYC(DEB_CYC)) u_up (
    .sys_clk (sys_clk),
    .srst    (srst),
    .ce      (ce),
    .raw     (buttons.up),
    .press   (up_press)
  );

  button_debounce #(.STABLE_CYC(DEB_CYC)) u_dn (
    .sys_clk (sys_clk),
    .srst    (srst),
    .ce      (ce),
    .raw     (buttons.down),
    .press   (dn_press)
  );

  // ==========================================================
  // Target adjust, saturating at limits
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      target <= fan_ui_pkg::TARGET_RESET;
    else if (ce)
    begin
      if (set_mode && up_press && target < TGT_MAX)
        target <= target + 8'sh01;
      else if (set_mode && dn_press && target > TGT_MIN)
        target <= target - 8'sh01;
    end
  end

  // Set mode entry and idle timeout
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      set_mode <= 1'b0;
      idle_reg <= 32'h0;
    end
    else if (ce)
    begin
      if (up_press || dn_press)
      begin
        set_mode <= 1'b1;
        idle_reg <= 32'h0;
      end
      else if (set_mode)
      begin
        if (idle_reg >= TIMEOUT_CYC - 1)
          set_mode <= 1'b0;
        else
          idle_reg <= idle_reg + 32'h1;
      end
      else
        idle_reg <= 32'h0;
    end
  end

  // Blink phase while setting
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      blink_cnt_reg <= 32'h0;
      blink_on_reg  <= 1'b1;
    end
    else if (ce)
    begin
      if (!set_mode)
      begin
        blink_cnt_reg <= 32'h0;
        blink_on_reg  <= 1'b1;
      end
      else if (blink_cnt_reg >= BLINK_CYC - 1)
      begin
        blink_cnt_reg <= 32'h0;
        blink_on_reg  <= ~blink_on_reg;
      end
      else
        blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  // ==========================================================
  // Speed curve from target minus actual
  assign diff = 9'(target) - 9'(temp_meas);

  always_comb
  begin
    if (diff > 9'(fan_ui_pkg::FULL_SPEED_DIFF))
      freq_next = FREQ_W'(FREQ_MAX);
    else if (diff <= 9'sd0)
      freq_next = FREQ_W'(FREQ_MIN);
    else
      freq_next = FREQ_W'(FREQ_MIN + ((FREQ_MAX - FREQ_MIN) * 32'(diff))
                  / 32'(fan_ui_pkg::FULL_SPEED_DIFF));
  end

  // Run state with hysteresis
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      run_reg <= ST_STOP;
    else if (ce)
    begin
      case (run_reg)
        ST_STOP:
          if (diff > 9'(fan_ui_pkg::START_DIFF))
            run_reg <= ST_RUN;
        ST_RUN:
          if (diff <= 9'(fan_ui_pkg::STOP_DIFF))
            run_reg <= ST_STOP;
        default:
          run_reg <= ST_STOP;
      endcase
    end
  end

  // Frequency command register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      motor_freq <= '0;
      motor_run  <= 1'b0;
    end
    else if (ce)
    begin
      motor_run  <= (run_reg == ST_RUN);
      motor_freq <= (run_reg == ST_RUN) ? freq_next : '0;
    end
  end

  // ==========================================================
  // Display multiplex, one digit at a time
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      mux_cnt_reg <= 32'h0;
      digit_reg   <= 1'b0;
    end
    else if (ce)
    begin
      if (mux_cnt_reg >= DIGIT_CYC - 1)
      begin
        mux_cnt_reg <= 32'h0;
        digit_reg   <= ~digit_reg;
      end
      else
        mux_cnt_reg <= mux_cnt_reg + 32'h1;
    end
  end

  // Value shown and its decimal digits; negatives show a minus on the tens digit
  always_comb
  begin
    shown = set_mode ? target : temp_meas;
    mag   = shown[7] ? 8'(-shown) : 8'(shown);
    if (mag > 8'h63)
      mag = 8'h63;
    tens  = 4'(mag / 8'h0a);
    ones  = 4'(mag % 8'h0a);
    if (shown[7] && digit_reg)
      nib = 4'hf;
    else
      nib = digit_reg ? tens : ones;
    case (nib)
      4'h0:    seg_pat = 7'h3f;
      4'h1:    seg_pat = 7'h06;
      4'h2:    seg_pat = 7'h5b;
      4'h3:    seg_pat = 7'h4f;
      4'h4:    seg_pat = 7'h66;
      4'h5:    seg_pat = 7'h6d;
      4'h6:    seg_pat = 7'h7d;
      4'h7:    seg_pat = 7'h07;
      4'h8:    seg_pat = 7'h7f;
      4'h9:    seg_pat = 7'h6f;
      4'hf:    seg_pat = 7'h40;
      default: seg_pat = 7'h00;
    endcase
  end

  // Registered segment and select lines, segments blanked in the off blink phase
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      led <= '0;
    else if (ce)
    begin
      led.seg       <= blink_on_reg ? seg_pat : 7'h00;
      led.digit_sel <= digit_reg ? 2'h2 : 2'h1;
    end
  end

  // ==========================================================
  // Checks
  property p_full_speed;
    @(posedge sys_clk) disable iff (srst)
    (ce && run_reg == ST_RUN && diff > 9'(fan_ui_pkg::FULL_SPEED_DIFF)) |=> (!ce || motor_freq == FREQ_MAX);
  endproperty
  a_full_speed: assert property (p_full_speed) else $error("full speed not commanded");

  property p_start;
    @(posedge sys_clk) disable iff (srst)
    (ce && run_reg == ST_STOP && diff <= 9'(fan_ui_pkg::START_DIFF)) |=> run_reg == ST_STOP;
  endproperty
  a_start: assert property (p_start) else $error("started too early");

  property p_hold_on;
    @(posedge sys_clk) disable iff (srst)
    (ce && run_reg == ST_RUN && diff > 9'(fan_ui_pkg::STOP_DIFF)) |=> run_reg == ST_RUN;
  endproperty
  a_hold_on: assert property (p_hold_on) else $error("stopped before zero difference");

  property p_one_digit;
    @(posedge sys_clk) disable iff (srst)
    !(led.digit_sel == 2'h3);
  endproperty
  a_one_digit: assert property (p_one_digit) else $error("both digits lit");

  property p_enter_set;
    @(posedge sys_clk) disable iff (srst)
    (ce && (up_press || dn_press)) |=> set_mode;
  endproperty
  a_enter_set: assert property (p_enter_set) else $error("press missed set mode");

  property p_step_up;
    @(posedge sys_clk) disable iff (srst)
    (ce && set_mode && up_press && target < TGT_MAX) |=> target == $past(target) + 8'sh01;
  endproperty
  a_step_up: assert property (p_step_up) else $error("up step wrong");

  property p_limits;
    @(posedge sys_clk) disable iff (srst)
    $rose(set_mode) |-> (target >= TGT_MIN && target <= TGT_MAX);
  endproperty
  a_limits: assert property (p_limits) else $error("target out of range");

  property p_stop_zero;
    @(posedge sys_clk) disable iff (srst)
    (motor_freq == '0) || (motor_freq >= FREQ_MIN && motor_run);
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("bad frequency command");

endmodule

// ===== plant_model.sv
// Far side model: temperature sensor reading and two push buttons with chatter.
// Assumes the bench sets the wanted levels just after a rising edge of sys_clk.
`timescale 1ns/100ps
module plant_model (
  input  wire logic              sys_clk,
  input  wire logic signed [7:0] temp_set,
  input  wire logic              up_hold,
  input  wire logic              down_hold,
  output logic signed [7:0]      temp_meas,
  output fan_ui_pkg::buttons_t   buttons
);
  logic [1:0] bounce_reg = 2'h0;
  logic       held_reg   = 1'b0;

  // ==========================================================
  // Sensor and contacts
  // A fresh press chatters high, low, high before it settles
  always_ff @(posedge sys_clk)
  begin
    temp_meas    <= temp_set;
    held_reg     <= up_hold | down_hold;
    bounce_reg   <= ((up_hold | down_hold) && !held_reg) ? 2'h2 : (bounce_reg >> 1);
    buttons.up   <= up_hold & ~bounce_reg[0];
    buttons.down <= down_hold & ~bounce_reg[0];
  end
endmodule

// ===== test_thermostat_fan_speed_ui.sv
// Self-checking bench for the fan speed controller with button and display interface.
// Assumes short timing parameters and the plant model on the sensor and button side.
`timescale 1ns/100ps
module test_thermostat_fan_speed_ui;
  localparam int unsigned DEB = 4;
  localparam int unsigned TMO = 200;
  logic                    sys_clk   = 1'b0;
  logic                    srst      = 1'b1;
  logic                    ce        = 1'b1;
  logic signed [7:0]       temp_set  = 8'sh14;
  logic                    up_hold   = 1'b0;
  logic                    down_hold = 1'b0;
  logic signed [7:0]       temp_meas;
  fan_ui_pkg::buttons_t    buttons;
  logic [7:0]              motor_freq;
  logic                    motor_run;
  fan_ui_pkg::led_drive_t  led;
  logic signed [7:0]       target;
  logic                    set_mode;
  int                      n_mismatch = 0;
  int                      compares   = 0;

  // ==========================================================
  // Clock, far side and design
  always #50 sys_clk = ~sys_clk;

  plant_model i_plant_model (.sys_clk(sys_clk), .temp_set(temp_set), .up_hold(up_hold),
    .down_hold(down_hold), .temp_meas(temp_meas), .buttons(buttons));

  fan_ui_ctrl #(.TIMEOUT_CYC(TMO), .DEB_CYC(DEB), .BLINK_CYC(10), .DIGIT_CYC(3)) i_fan_ui_ctrl (
    .sys_clk(sys_clk), .srst(srst), .ce(ce), .temp_meas(temp_meas), .buttons(buttons),
    .motor_freq(motor_freq), .motor_run(motor_run), .led(led), .target(target), .set_mode(set_mode));

  // ==========================================================
  // Helpers
  // Compare one value and count it
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Wait whole cycles, then let the edge's updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // One press: chatter, settle, hold, release, settle again
  task automatic press(input logic up, input int hold);
    @(posedge sys_clk);
    up_hold   <= up;
    down_hold <= !up;
    tick(DEB + 4 + hold);
    @(posedge sys_clk);
    up_hold   <= 1'b0;
    down_hold <= 1'b0;
    tick(DEB + 4);
  endtask

  // ==========================================================
  // Scenarios
  // Speed curve across the hysteresis band and full speed region
  task automatic test_motor;
    int         tt[8] = '{19, 18, 17, 15, 14, 0, 19, 20};
    logic [7:0] ff[8] = '{8'h00, 8'h24, 8'h2c, 8'h3c, 8'h3c, 8'h3c, 8'h1c, 8'h00};
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      temp_set <= 8'(tt[i]);
      tick(5);
      check_val(motor_freq, ff[i], "motor freq");
      check_val({7'h0, motor_run}, {7'h0, ff[i] != 8'h00}, "motor run");
    end
  endtask

  // Clock enable low freezes the run state; raising it lets the curve act again
  task automatic test_enable;
    @(posedge sys_clk);
    ce       <= 1'b0;
    temp_set <= 8'sh0a;
    tick(6);
    check_val({7'h0, motor_run}, 8'h00, "frozen run");
    check_val(motor_freq, 8'h00, "frozen freq");
    @(posedge sys_clk);
    ce <= 1'b1;
    tick(5);
    check_val(motor_freq, 8'h3c, "enabled freq");
    @(posedge sys_clk);
    temp_set <= 8'sh14;
    tick(5);
    check_val(motor_freq, 8'h00, "stopped again");
  endtask

  // Two digits of the measured value, then blinking target after a press
  task automatic test_display;
    int blank = 0;
    int lit   = 0;
    @(posedge sys_clk);
    temp_set <= 8'sh19;
    tick(8);
    for (int i = 0; i < 12; i++)
    begin
      tick(1);
      check_val({7'h0, led.digit_sel == 2'b01 || led.digit_sel == 2'b10}, 8'h01, "one digit");
      if (led.digit_sel == 2'b10)
        check_val({1'b0, led.seg}, 8'h5b, "tens digit");
      if (led.digit_sel == 2'b01)
        check_val({1'b0, led.seg}, 8'h6d, "ones digit");
    end
    press(1'b1, 0);
    check_val({7'h0, set_mode}, 8'h01, "set mode on");
    check_val(target, 8'h14, "first press no step");
    for (int i = 0; i < 40; i++)
    begin
      tick(1);
      if (led.seg == 7'h00)
        blank++;
      else
      begin
        lit++;
        if (led.digit_sel == 2'b01)
          check_val({1'b0, led.seg}, 8'h3f, "target ones");
      end
    end
    check_val({7'h0, blank > 0 && lit > 0}, 8'h01, "blinking");
  endtask

  // Steps, held button, saturation and idle timeout
  task automatic test_buttons;
    press(1'b1, 0);
    check_val(target, 8'h15, "up step");
    press(1'b1, 30);
    check_val(target, 8'h16, "held no repeat");
    press(1'b0, 0);
    check_val(target, 8'h15, "down step");
    repeat (15) press(1'b1, 0);
    check_val(target, 8'h23, "upper limit");
    tick(150);
    check_val({7'h0, set_mode}, 8'h01, "still setting");
    tick(80);
    check_val({7'h0, set_mode}, 8'h00, "timeout");
    for (int i = 0; i < 6; i++)
    begin
      tick(1);
      if (led.digit_sel == 2'b10)
        check_val({1'b0, led.seg}, 8'h5b, "measured again");
    end
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    tick(12);
    check_val(target, 8'h14, "reset target");
    check_val({motor_freq[6:0], set_mode}, 8'h00, "reset outputs");
    check_val({led.seg, motor_run}, 8'h00, "reset display");
    @(posedge sys_clk);
    srst <= 1'b0;
    test_motor();
    test_enable();
    test_display();
    test_buttons();
    report_and_stop();
  end

  // Cuts a hang short well past the expected run length
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
